// File: rtl/dsc_conv_ctrl.sv
// conversion control for the dual simultaneous sampling converter
`default_nettype none
module dsc_conv_ctrl #(
  parameter int RES = dsc_pkg::RES_NARROW
) (
  input  wire logic           sys_clk,
  input  wire logic           rst,
  input  wire logic           convert_start_n,
  input  wire logic           input_span_sel0,
  input  wire logic           input_span_sel1,
  input  wire logic           pair_select,
  input  wire logic           reference_source_strap,
  input  wire logic           cmp_a_above,
  input  wire logic           cmp_b_above,
  input  wire logic           serial_clk,
  input  wire logic           read_select_n,
  output logic                busy,
  output logic                track_hold,
  output logic                pair_route,
  output logic [1:0]          span_code,
  output logic                internal_ref_on,
  output logic [RES-1:0]      dac_a_trial,
  output logic [RES-1:0]      dac_b_trial,
  output logic                dout_a,
  output logic                dout_b
);
  localparam int NP = dsc_pkg::PIN_COUNT;
  localparam int CONV_CYC = RES + 2;
  localparam logic [RES-1:0] ZERO_R = '0;

  // only the two documented result widths are served
  if (RES != dsc_pkg::RES_NARROW && RES != dsc_pkg::RES_WIDE) begin : g_bad_res
    $error("RES must be 12 or 14");
  end

  // sign flip of the top bit turns offset binary into twos complement
  function automatic logic [RES-1:0] to_twos(input logic [RES-1:0] raw);
    to_twos = {~raw[RES-1], raw[RES-2:0]};
  endfunction

  // span code accepted only when legal, else the old one stays
  function automatic logic [1:0] span_pick(input logic [1:0] pin, input logic [1:0] old);
    span_pick = (pin == dsc_pkg::SPAN_ILLEGAL) ? old : pin;
  endfunction

  // pin synchronisers: order is start, span1, span0, pair, strap
  logic [NP-1:0] pin_s1;
  logic [NP-1:0] pin_s2;
  logic          cnv_prev;
  logic          cnv_s;
  logic [1:0]    span_s;
  logic          pair_s;
  logic          strap_s;
  logic          cnv_fall;

  // synchronisers run through reset, so the strap is settled at release
  always_ff @(posedge sys_clk) begin
    pin_s1 <= {convert_start_n, input_span_sel1, input_span_sel0, pair_select, reference_source_strap};
    pin_s2 <= pin_s1;
    if (rst) begin
      cnv_prev <= dsc_pkg::CNV_IDLE;
    end else begin
      cnv_prev <= pin_s2[NP-1];
    end
  end

  // synchronised levels and the start edge
  assign cnv_s    = pin_s2[NP-1];
  assign span_s   = pin_s2[NP-2:NP-3];
  assign pair_s   = pin_s2[1];
  assign strap_s  = pin_s2[0];
  assign cnv_fall = cnv_prev & ~cnv_s;

  // the two converters
  logic           core_start;
  logic           done_a, done_b;
  logic [RES-1:0] raw_a, raw_b;

  dsc_sar_core #(.W(RES)) u_sar_a (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .start     (core_start),
    .cmp_above (cmp_a_above),
    .trial     (dac_a_trial),
    .done      (done_a),
    .code      (raw_a)
  );

  dsc_sar_core #(.W(RES)) u_sar_b (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .start     (core_start),
    .cmp_above (cmp_b_above),
    .trial     (dac_b_trial),
    .done      (done_b),
    .code      (raw_b)
  );

  // controller state
  dsc_pkg::dsc_state_t state;
  dsc_pkg::dsc_state_t next_state;
  logic           pair_next;
  logic           ref_taken;
  logic           word_toggle;
  logic [RES-1:0] result_a, result_b;
  logic           next_busy;
  logic           next_hold;
  logic           next_pair_route;
  logic           next_pair_next;
  logic [1:0]     next_span;
  logic           next_ref_on;
  logic           next_ref_taken;
  logic           next_start;
  logic           next_toggle;
  logic [RES-1:0] next_result_a, next_result_b;

  // track, convert and return to track
  always_comb begin
    next_state      = state;
    next_busy       = busy;
    next_hold       = track_hold;
    next_pair_route = pair_route;
    next_pair_next  = pair_next;
    next_span       = span_code;
    next_ref_on     = internal_ref_on;
    next_ref_taken  = ref_taken;
    next_start      = 1'b0;
    next_toggle     = word_toggle;
    next_result_a   = result_a;
    next_result_b   = result_b;
    // strap caught once after reset release
    if (!ref_taken) begin
      next_ref_on    = (strap_s == dsc_pkg::REF_INTERNAL);
      next_ref_taken = 1'b1;
    end
    case (state)
      dsc_pkg::DSC_TRACK: begin
        if (cnv_fall) begin
          next_state     = dsc_pkg::DSC_CONVERT;
          next_hold      = dsc_pkg::HOLD_ON;
          next_start     = 1'b1;
          next_busy      = 1'b1;
          next_pair_next = pair_s;
          next_span      = span_pick(span_s, span_code);
        end
      end
      dsc_pkg::DSC_CONVERT: begin
        if (done_a && done_b) begin
          next_state      = dsc_pkg::DSC_TRACK;
          next_busy       = 1'b0;
          next_hold       = dsc_pkg::TRACK_ON;
          next_pair_route = pair_next;
          next_result_a   = to_twos(raw_a);
          next_result_b   = to_twos(raw_b);
          next_toggle     = ~word_toggle;
        end
      end
      default: begin
        next_state = dsc_pkg::DSC_TRACK;
        next_busy  = 1'b0;
        next_hold  = dsc_pkg::TRACK_ON;
      end
    endcase
  end

  // register the controller state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state           <= dsc_pkg::DSC_TRACK;
      busy            <= 1'b0;
      track_hold      <= dsc_pkg::TRACK_ON;
      pair_route      <= dsc_pkg::PAIR_FIRST;
      pair_next       <= dsc_pkg::PAIR_FIRST;
      span_code       <= dsc_pkg::SPAN_BIPOLAR_10;
      internal_ref_on <= 1'b0;
      ref_taken       <= 1'b0;
      core_start      <= 1'b0;
      word_toggle     <= 1'b0;
      result_a        <= ZERO_R;
      result_b        <= ZERO_R;
    end else begin
      state           <= next_state;
      busy            <= next_busy;
      track_hold      <= next_hold;
      pair_route      <= next_pair_route;
      pair_next       <= next_pair_next;
      span_code       <= next_span;
      internal_ref_on <= next_ref_on;
      ref_taken       <= next_ref_taken;
      core_start      <= next_start;
      word_toggle     <= next_toggle;
      result_a        <= next_result_a;
      result_b        <= next_result_b;
    end
  end

  // results leave on the host's serial clock
  dsc_serial_out #(.W(RES)) u_serial (
    .serial_clk    (serial_clk),
    .rst           (rst),
    .read_select_n (read_select_n),
    .word_a        (result_a),
    .word_b        (result_b),
    .word_toggle   (word_toggle),
    .dout_a        (dout_a),
    .dout_b        (dout_b)
  );

  // busy cycle counter, only read by the length check
  localparam int BCW = $clog2(CONV_CYC + 2);
  localparam logic [BCW-1:0] ZERO_B = '0;
  logic [BCW-1:0] busy_cnt;
  logic [BCW-1:0] next_busy_cnt;

  // counts up while busy, clears when idle
  always_comb begin
    next_busy_cnt = ZERO_B;
    if (busy) begin
      next_busy_cnt = busy_cnt + 1'b1;
    end
  end

  // register the busy counter
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_cnt <= ZERO_B;
    end else begin
      busy_cnt <= next_busy_cnt;
    end
  end

  // checks on the controller
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);

  // start, busy, pair, span and result checks
  a_start_holds: assert property (
    (state == dsc_pkg::DSC_TRACK && cnv_fall) |=> track_hold && busy && core_start)
    else $error("start edge did not hold and start");
  a_start_pulse: assert property (
    core_start |=> !core_start) else $error("start pulse too long");
  a_busy_length: assert property (
    $fell(busy) |-> busy_cnt == BCW'(CONV_CYC)) else $error("busy length wrong");
  a_stray_ignored: assert property (
    (state == dsc_pkg::DSC_CONVERT && cnv_fall && !(done_a && done_b)) |=> busy)
    else $error("start edge taken during conversion");
  a_busy_ends: assert property (
    $fell(busy) |-> $past(done_a) && $past(done_b)) else $error("busy fell before both done");
  a_track_after: assert property (
    $fell(busy) |-> track_hold == dsc_pkg::TRACK_ON) else $error("no tracking after busy");
  a_hold_busy: assert property (
    busy |-> track_hold == dsc_pkg::HOLD_ON) else $error("tracking while busy");
  a_pair_latch: assert property (
    $rose(busy) |-> pair_next == $past(pair_s) ##1 $stable(pair_route))
    else $error("pair not latched at busy rise");
  a_pair_applies: assert property (
    $fell(busy) |-> pair_route == $past(pair_next)) else $error("pair not applied");
  a_pair_default: assert property (
    $fell(rst) |-> pair_route == dsc_pkg::PAIR_FIRST) else $error("default pair wrong");
  a_twos_result: assert property (
    $fell(busy) |-> result_a[RES-1] == ~$past(raw_a[RES-1]) && result_b[RES-1] == ~$past(raw_b[RES-1]))
    else $error("result not twos complement");
  a_span_legal: assert property (
    span_code != dsc_pkg::SPAN_ILLEGAL) else $error("illegal span applied");
  a_conv_bound: assert property (
    $rose(busy) |-> ##[1:CONV_CYC] $fell(busy)) else $error("conversion too long");

  // configuration and tracking
  a_hold_idle: assert property (
    !busy |-> track_hold == dsc_pkg::TRACK_ON) else $error("holding while idle");
  a_span_taken: assert property (
    ($rose(busy) && ($past(span_s) != dsc_pkg::SPAN_ILLEGAL)) |-> span_code == $past(span_s))
    else $error("legal span not applied");
  a_span_kept: assert property (
    ($rose(busy) && ($past(span_s) == dsc_pkg::SPAN_ILLEGAL)) |-> $stable(span_code))
    else $error("illegal span not ignored");
  a_ref_fixed: assert property (
    (ref_taken && $past(ref_taken)) |-> $stable(internal_ref_on)) else $error("reference source changed");

  c_second_pair: cover property ($fell(busy) && pair_route == dsc_pkg::PAIR_SECOND);
  c_unipolar: cover property ($fell(busy) && span_code == dsc_pkg::SPAN_UNIPOLAR);
  c_external_ref: cover property ($rose(ref_taken) && !next_ref_on);
  c_back_to_back: cover property ($fell(busy) ##[1:20] $rose(busy));
  c_refused_start: cover property (state == dsc_pkg::DSC_CONVERT && cnv_fall);
endmodule
`default_nettype wire

// File: rtl/dsc_pkg.sv
// shared constants and types of the dual converter control
`default_nettype none
package dsc_pkg;
  // result widths of the two variants
  localparam int RES_NARROW = 12;
  localparam int RES_WIDE   = 14;
  // input span codes as seen on the two select pins
  localparam logic [1:0] SPAN_BIPOLAR_10 = 2'h0;
  localparam logic [1:0] SPAN_BIPOLAR_5  = 2'h1;
  localparam logic [1:0] SPAN_UNIPOLAR   = 2'h2;
  localparam logic [1:0] SPAN_ILLEGAL    = 2'h3;
  // channel pair codes
  localparam logic PAIR_FIRST  = 1'h0;
  localparam logic PAIR_SECOND = 1'h1;
  // reference strap level for the internal source
  localparam logic REF_INTERNAL = 1'h1;
  // idle and reset levels
  localparam logic CNV_IDLE   = 1'h1;
  localparam logic SEL_IDLE   = 1'h1;
  localparam logic LEVEL_LOW  = 1'h0;
  localparam logic HOLD_ON    = 1'h1;
  localparam logic TRACK_ON   = 1'h0;
  // number of pin inputs on the synchroniser
  localparam int PIN_COUNT = 5;
  // controller states
  typedef enum logic {
    DSC_TRACK,
    DSC_CONVERT
  } dsc_state_t;
endpackage
`default_nettype wire

// File: rtl/dsc_sar_core.sv
// successive approximation sequencer for one converter
`default_nettype none
module dsc_sar_core #(
  parameter int W = dsc_pkg::RES_NARROW
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic         cmp_above,
  output logic [W-1:0]      trial,
  output logic              done,
  output logic [W-1:0]      code
);
  localparam int IW = $clog2(W);
  localparam logic [W-1:0] TOP_BIT = {1'b1, {(W-1){1'b0}}};
  localparam logic [W-1:0] ZERO_W  = '0;
  localparam logic [IW-1:0] TOP_IDX = IW'(W - 1);
  localparam logic [IW-1:0] ZERO_I  = '0;
  localparam int STEPS = W + 1;

  logic [IW-1:0] idx;
  logic          running;
  logic [W-1:0]  next_trial;
  logic [W-1:0]  next_code;
  logic [IW-1:0] next_idx;
  logic          next_running;
  logic          next_done;
  logic [W-1:0]  kept;

  // one trial bit per oscillator cycle, msb first
  always_comb begin
    kept         = trial;
    next_trial   = trial;
    next_code    = code;
    next_idx     = idx;
    next_running = running;
    next_done    = 1'b0;
    if (start) begin
      next_trial   = TOP_BIT;
      next_idx     = TOP_IDX;
      next_running = 1'b1;
    end else if (running) begin
      if (!cmp_above) begin
        kept[idx] = 1'b0; // input below trial: drop the bit
      end
      next_trial = kept;
      if (idx == ZERO_I) begin
        next_running = 1'b0;
        next_done    = 1'b1;
        next_code    = kept;
      end else begin
        next_idx             = idx - 1'b1;
        next_trial[idx-1'b1] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      trial   <= ZERO_W;
      code    <= ZERO_W;
      idx     <= ZERO_I;
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      trial   <= next_trial;
      code    <= next_code;
      idx     <= next_idx;
      running <= next_running;
      done    <= next_done;
    end
  end

  // conversion finishes a fixed number of cycles after start
  a_sar_length: assert property (@(posedge sys_clk) disable iff (rst)
    start |-> ##STEPS done) else $error("sar did not finish in time");
endmodule
`default_nettype wire

// File: rtl/dsc_serial_out.sv
// serial result shifter on the host's serial clock
`default_nettype none
module dsc_serial_out #(
  parameter int W = dsc_pkg::RES_NARROW
) (
  input  wire logic         serial_clk,
  input  wire logic         rst,
  input  wire logic         read_select_n,
  input  wire logic [W-1:0] word_a,
  input  wire logic [W-1:0] word_b,
  input  wire logic         word_toggle,
  output logic              dout_a,
  output logic              dout_b
);
  localparam int CW = $clog2(W + 1);
  localparam logic [CW-1:0] ZERO_C = '0;
  localparam logic [CW-1:0] LAST_C = CW'(W - 1);
  localparam logic [W-1:0]  ZERO_W = '0;

  logic          rst_s1, rst_s2;
  logic          tog_s1, tog_s2;
  logic          taken;
  logic [CW-1:0] left;
  logic [W-1:0]  sh_a, sh_b;
  logic          next_taken;
  logic [CW-1:0] next_left;
  logic [W-1:0]  next_sh_a, next_sh_b;
  logic          next_dout_a, next_dout_b;

  // reset and result toggle brought into the link domain
  always_ff @(posedge serial_clk) begin
    rst_s1 <= rst;
    rst_s2 <= rst_s1;
    tog_s1 <= word_toggle;
    tog_s2 <= tog_s1;
  end

  // new result loads on the first edge of a frame, then msb first
  always_comb begin
    next_taken  = taken;
    next_left   = left;
    next_sh_a   = sh_a;
    next_sh_b   = sh_b;
    next_dout_a = dout_a;
    next_dout_b = dout_b;
    if (!read_select_n) begin
      if (tog_s2 != taken) begin
        next_taken  = tog_s2;
        next_left   = LAST_C;
        next_dout_a = word_a[W-1];
        next_dout_b = word_b[W-1];
        next_sh_a   = word_a << 1;
        next_sh_b   = word_b << 1;
      end else if (left != ZERO_C) begin
        next_left   = left - 1'b1;
        next_dout_a = sh_a[W-1];
        next_dout_b = sh_b[W-1];
        next_sh_a   = sh_a << 1;
        next_sh_b   = sh_b << 1;
      end
    end
  end

  always_ff @(posedge serial_clk) begin
    if (rst_s2) begin
      taken  <= 1'b0;
      left   <= ZERO_C;
      sh_a   <= ZERO_W;
      sh_b   <= ZERO_W;
      dout_a <= 1'b0;
      dout_b <= 1'b0;
    end else begin
      taken  <= next_taken;
      left   <= next_left;
      sh_a   <= next_sh_a;
      sh_b   <= next_sh_b;
      dout_a <= next_dout_a;
      dout_b <= next_dout_b;
    end
  end
endmodule
`default_nettype wire

// File: verif/dsc_host_model.sv
// host-side model: convert-start pin and serial readout frames
`default_nettype none
module dsc_host_model #(
  parameter int RES = dsc_pkg::RES_NARROW
) (
  input  wire logic sys_clk,
  input  wire logic busy,
  input  wire logic dout_a,
  input  wire logic dout_b,
  output logic      convert_start_n,
  output logic      serial_clk,
  output logic      read_select_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle levels; the link clock rests low between pulses
  initial begin
    convert_start_n = dsc_pkg::CNV_IDLE;
    serial_clk      = dsc_pkg::LEVEL_LOW;
    read_select_n   = dsc_pkg::SEL_IDLE;
  end

  // one 64 ns link clock pulse
  task automatic link_pulse();
    #32 serial_clk = 1'h1;
    #32 serial_clk = 1'h0;
  endtask

  // acquisition gap, then a start edge held until busy answers
  task automatic convert(input int unsigned gap, output int unsigned lat);
    lat = 0;
    while (busy !== 1'h0) @(posedge sys_clk);
    repeat (gap) @(posedge sys_clk);
    convert_start_n <= 1'h0;
    do begin
      @(posedge sys_clk);
      #1;
      lat++;
    end while (busy !== 1'h1 && lat < 20);
    @(posedge sys_clk);
    convert_start_n <= 1'h1;
  endtask

  // start edge issued while a conversion still runs
  task automatic stray_start();
    @(posedge sys_clk);
    convert_start_n <= 1'h0;
    repeat (4) @(posedge sys_clk);
    convert_start_n <= 1'h1;
  endtask

  // idle pulses let the new result cross, then one frame of both words
  task automatic read_frame(output logic [RES-1:0] a, output logic [RES-1:0] b);
    a = '0;
    b = '0;
    repeat (4) link_pulse();
    read_select_n = 1'h0;
    repeat (RES) begin
      link_pulse();
      a = {a[RES-2:0], dout_a};
      b = {b[RES-2:0], dout_b};
    end
    #16 read_select_n = 1'h1;
  endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the dual converter control
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RES = dsc_pkg::RES_NARROW;
  localparam logic [RES-1:0] MSB = {1'h1, {(RES-1){1'h0}}};
  // offset-binary levels on first and second inputs of each converter
  localparam logic [RES-1:0] VIN_A [2] = '{12'h000, 12'h800};
  localparam logic [RES-1:0] VIN_B [2] = '{12'hFFF, 12'h123};

  logic           sys_clk;
  logic           rst;
  logic           convert_start_n;
  logic           input_span_sel0;
  logic           input_span_sel1;
  logic           pair_select;
  logic           reference_source_strap;
  logic           cmp_a_above;
  logic           cmp_b_above;
  logic           serial_clk;
  logic           read_select_n;
  logic           busy;
  logic           track_hold;
  logic           pair_route;
  logic [1:0]     span_code;
  logic           internal_ref_on;
  logic [RES-1:0] dac_a_trial;
  logic [RES-1:0] dac_b_trial;
  logic           dout_a;
  logic           dout_b;
  int             miscompares;
  int             tests_run;
  int unsigned    busy_len;
  logic           cur_pair;

  // comparators against the routed input pair
  assign cmp_a_above = (dac_a_trial <= VIN_A[pair_route]);
  assign cmp_b_above = (dac_b_trial <= VIN_B[pair_route]);

  dsc_conv_ctrl #(.RES(RES)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .convert_start_n(convert_start_n),
    .input_span_sel0(input_span_sel0), .input_span_sel1(input_span_sel1),
    .pair_select(pair_select), .reference_source_strap(reference_source_strap),
    .cmp_a_above(cmp_a_above), .cmp_b_above(cmp_b_above), .serial_clk(serial_clk),
    .read_select_n(read_select_n), .busy(busy), .track_hold(track_hold),
    .pair_route(pair_route), .span_code(span_code), .internal_ref_on(internal_ref_on),
    .dac_a_trial(dac_a_trial), .dac_b_trial(dac_b_trial), .dout_a(dout_a), .dout_b(dout_b)
  );

  dsc_host_model #(.RES(RES)) host_u (
    .sys_clk(sys_clk), .busy(busy), .dout_a(dout_a), .dout_b(dout_b),
    .convert_start_n(convert_start_n), .serial_clk(serial_clk), .read_select_n(read_select_n)
  );

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  // compare and count
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // busy length and hold level watched every cycle
  always @(posedge sys_clk) begin
    if (rst === 1'h1) begin
      busy_len <= 0;
    end else begin
      if (track_hold !== busy) check("track_hold", {15'h0, busy}, {15'h0, track_hold});
      if (busy === 1'h1) begin
        busy_len <= busy_len + 1;
      end else if (busy_len != 0) begin
        check("busy length", 16'(RES + 2), 16'(busy_len));
        busy_len <= 0;
      end
    end
  end

  // reset with both domains clocked, then check power-up state
  task automatic do_reset(input logic strap);
    @(posedge sys_clk);
    rst <= 1'h1;
    reference_source_strap <= strap;
    repeat (4) host_u.link_pulse();
    @(posedge sys_clk);
    rst <= 1'h0;
    repeat (4) @(posedge sys_clk);
    #1;
    cur_pair = dsc_pkg::PAIR_FIRST;
    check("internal_ref_on", {15'h0, strap}, {15'h0, internal_ref_on});
    check("pair_route", {15'h0, dsc_pkg::PAIR_FIRST}, {15'h0, pair_route});
    check("busy", 16'h0000, {15'h0, busy});
  endtask

  // one conversion: start, refused restart when stray is set, latch checks, readout
  task automatic run_conv(input logic [1:0] span, input logic psel, input logic [1:0] exp_span,
                          input int unsigned gap, input bit stray);
    int unsigned lat;
    int unsigned n;
    logic [RES-1:0] ra;
    logic [RES-1:0] rb;
    @(posedge sys_clk);
    {input_span_sel1, input_span_sel0} <= span;
    pair_select <= psel;
    host_u.convert(gap, lat);
    check("start latency", 16'h0003, 16'(lat));
    check("span_code", {14'h0, exp_span}, {14'h0, span_code});
    pair_select <= ~psel;
    {input_span_sel1, input_span_sel0} <= 2'h0;
    if (stray) host_u.stray_start();
    n = 0;
    while (busy !== 1'h0 && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("pair_route", {15'h0, psel}, {15'h0, pair_route});
    check("span kept", {14'h0, exp_span}, {14'h0, span_code});
    if (stray) begin
      repeat (10) @(posedge sys_clk);
      #1;
      check("busy after stray", 16'h0000, {15'h0, busy});
    end
    host_u.read_frame(ra, rb);
    check("result a", 16'(VIN_A[cur_pair] ^ MSB), 16'(ra));
    check("result b", 16'(VIN_B[cur_pair] ^ MSB), 16'(rb));
    cur_pair = psel;
  endtask

  // closing report
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // main sequence: four spans incl. the illegal code, then a second reset
  initial begin
    sys_clk = 1'h0;
    rst = 1'h1;
    input_span_sel0 = 1'h0;
    input_span_sel1 = 1'h0;
    pair_select = 1'h0;
    reference_source_strap = dsc_pkg::REF_INTERNAL;
    miscompares = 0;
    tests_run = 0;
    cur_pair = dsc_pkg::PAIR_FIRST;
    do_reset(1'h1);
    run_conv(dsc_pkg::SPAN_BIPOLAR_10, 1'h1, 2'h0, 8, 0);
    run_conv(dsc_pkg::SPAN_BIPOLAR_5, 1'h1, 2'h1, 30, 1);
    run_conv(dsc_pkg::SPAN_UNIPOLAR, 1'h0, 2'h2, 8, 0);
    run_conv(dsc_pkg::SPAN_ILLEGAL, 1'h1, 2'h2, 12, 0);
    do_reset(1'h0);
    run_conv(dsc_pkg::SPAN_BIPOLAR_5, 1'h1, 2'h1, 8, 0);
    give_verdict();
  end

  // watchdog for a hung handshake
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end
endmodule
`default_nettype wire
